// ===== rtl/tcfc_top.sv
// timer channel select, compare force, channel 7 override and main counter
// assumes apb master on clk; tick_in is a same-clock prescaler strobe
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module tcfc_top #(
  parameter int unsigned NUM_CH = tcfc_pkg::NUM_CH,
  parameter int unsigned CNT_W = tcfc_pkg::CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // prescaler tick from the same clock domain
  input wire logic tick_in,
  // timer port pins
  output logic [NUM_CH-1:0] pin_out,
  output logic [NUM_CH-1:0] pin_oe,
  // interrupt
  output logic irq
);
  // software registers
  logic [7:0] func_sel_q;
  logic [7:0] c7_mask_q;
  logic [7:0] c7_data_q;
  logic [7:0] tov_q;
  logic [15:0] action_q;
  logic [1:0] ctrl_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_mask_q;
  logic [7:0] irq_stat_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_prev_q;
  logic [7:0] pins_q;
  logic [7:0] pins_d;
  logic [7:0] oe_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic rd_pend_q;
  logic [CNT_W*NUM_CH-1:0] cmp_words;
  logic [CNT_W-1:0] bank_rd;

  // access decode: each transfer is answered the cycle after its first access cycle, compare reads one cycle later
  tcfc_pkg::tcfc_req_t req;
  wire acc = psel && penable && !pready_q;
  wire addr_ok_align = (paddr[1:0] == 2'b00);
  assign req.wr = acc && pwrite;
  assign req.rd = acc && !pwrite;
  assign req.idx = paddr[9:2];
  assign req.data = pwdata;
  wire lane0 = pstrb[0];
  wire lane1 = pstrb[1];

  wire is_cmp = (req.idx >= tcfc_pkg::IDX_CMP_BASE) &&
    (req.idx < tcfc_pkg::IDX_CMP_BASE + 8'h08);
  wire [7:0] cmp_off = req.idx - tcfc_pkg::IDX_CMP_BASE;
  wire is_known = (req.idx == tcfc_pkg::IDX_FUNC_SEL) || (req.idx == tcfc_pkg::IDX_FORCE) ||
    (req.idx == tcfc_pkg::IDX_C7_MASK) || (req.idx == tcfc_pkg::IDX_C7_DATA) ||
    (req.idx == tcfc_pkg::IDX_CNT_HI) || (req.idx == tcfc_pkg::IDX_CNT_LO) ||
    (req.idx == tcfc_pkg::IDX_TOGGLE_OVF) || (req.idx == tcfc_pkg::IDX_CNT_WORD) ||
    (req.idx == tcfc_pkg::IDX_ACTION) || (req.idx == tcfc_pkg::IDX_CTRL) ||
    (req.idx == tcfc_pkg::IDX_IRQ_STAT) || (req.idx == tcfc_pkg::IDX_IRQ_MASK) ||
    (req.idx == tcfc_pkg::IDX_PIN_STATE) || is_cmp;
  wire bad = !addr_ok_align || !is_known || (paddr[11:10] != 2'b00);
  wire wr_ok = req.wr && !bad;

  function automatic logic hit(input logic [7:0] idx);
    hit = wr_ok && (req.idx == idx) && lane0;
  endfunction

  // force is a pulse only, nothing is stored
  wire [7:0] force_pls = hit(tcfc_pkg::IDX_FORCE) ? req.data[7:0] : 8'h00;
  wire en = ctrl_q[tcfc_pkg::CTRL_EN_BIT];
  wire test_mode = ctrl_q[tcfc_pkg::CTRL_TEST_BIT];
  // counter byte writes only in test mode; word write also test mode only
  wire wr_hi = hit(tcfc_pkg::IDX_CNT_HI) && test_mode;
  wire wr_lo = hit(tcfc_pkg::IDX_CNT_LO) && test_mode;
  wire wr_word = wr_ok && (req.idx == tcfc_pkg::IDX_CNT_WORD) && test_mode && lane0 && lane1;
  wire step = en && tick_in;

  // counter next value; a write does not realign the tick, so the first
  // interval after it may be short or long
  always_comb
  begin
    cnt_d = cnt_q;
    if (step)
      cnt_d = cnt_q + 16'h0001;
    if (wr_word)
      cnt_d = req.data[15:0];
    else if (wr_hi)
      cnt_d = {req.data[7:0], cnt_q[7:0]};
    else if (wr_lo)
      cnt_d = {cnt_q[15:8], req.data[7:0]};
  end
  wire ovf = step && (cnt_q == 16'hffff) && !(wr_word || wr_hi || wr_lo);

  // compare match: fires once when the counter steps onto the value
  logic [7:0] match;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      match[i] = func_sel_q[i] && step &&
        (cnt_q + 16'h0001 == cmp_words[i*CNT_W +: CNT_W]);
  end

  function automatic logic apply(input logic cur, input logic [1:0] act);
    case (act)
      tcfc_pkg::TCFC_ACT_TOGGLE: apply = !cur;
      tcfc_pkg::TCFC_ACT_CLEAR: apply = 1'b0;
      tcfc_pkg::TCFC_ACT_SET: apply = 1'b1;
      default: apply = cur;
    endcase
  endfunction

  // pin update, highest priority last
  wire c7_evt = func_sel_q[7] && (match[7] || force_pls[7]);
  always_comb
  begin
    pins_d = pins_q;
    for (int i = 0; i < 8; i++)
    begin
      if (func_sel_q[i] && (match[i] || force_pls[i]))
        pins_d[i] = apply(pins_q[i], action_q[2*i +: 2]);
      if (func_sel_q[i] && tov_q[i] && ovf)
        pins_d[i] = !pins_q[i];
      if (c7_evt && c7_mask_q[i])
        pins_d[i] = c7_data_q[i];
    end
  end

  // output enables follow action, channel 7 mask (not on ch7) or overflow toggle on compare channels
  logic [7:0] oe_d;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      oe_d[i] = func_sel_q[i] && ((action_q[2*i +: 2] != 2'b00) ||
        (c7_mask_q[i] && (i < 7)) || tov_q[i]);
  end

  // flags: real compares only, and not for a channel forced in the same cycle
  wire [7:0] flag_set = match & ~force_pls;
  wire [7:0] flag_clr = hit(tcfc_pkg::IDX_IRQ_STAT) ? req.data[7:0] : 8'h00;
  assign irq_stat_d = (irq_stat_q & ~flag_clr) | flag_set; // set wins

  // register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      func_sel_q <= tcfc_pkg::RST_BYTE;
      c7_mask_q <= tcfc_pkg::RST_BYTE;
      c7_data_q <= tcfc_pkg::RST_BYTE;
      tov_q <= tcfc_pkg::RST_BYTE;
      irq_mask_q <= tcfc_pkg::RST_BYTE;
      action_q <= tcfc_pkg::RST_ACTION;
      ctrl_q <= 2'b00;
    end
    else
    begin
      if (hit(tcfc_pkg::IDX_FUNC_SEL))
        func_sel_q <= req.data[7:0];
      if (hit(tcfc_pkg::IDX_C7_MASK))
        c7_mask_q <= req.data[7:0];
      if (hit(tcfc_pkg::IDX_C7_DATA))
        c7_data_q <= req.data[7:0];
      if (hit(tcfc_pkg::IDX_TOGGLE_OVF))
        tov_q <= req.data[7:0];
      if (hit(tcfc_pkg::IDX_IRQ_MASK))
        irq_mask_q <= req.data[7:0];
      if (wr_ok && (req.idx == tcfc_pkg::IDX_ACTION) && lane0 && lane1)
        action_q <= req.data[15:0];
      if (hit(tcfc_pkg::IDX_CTRL))
        ctrl_q <= req.data[1:0];
    end
  end

  // timer state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= tcfc_pkg::RST_CNT;
      cnt_prev_q <= tcfc_pkg::RST_CNT;
      pins_q <= tcfc_pkg::RST_BYTE;
      oe_q <= tcfc_pkg::RST_BYTE;
      irq_stat_q <= tcfc_pkg::RST_BYTE;
    end
    else
    begin
      cnt_q <= cnt_d;
      cnt_prev_q <= cnt_q;
      pins_q <= pins_d;
      oe_q <= oe_d;
      irq_stat_q <= irq_stat_d;
    end
  end

  // compare store; write needs both low lanes
  wire bank_wr = wr_ok && is_cmp && lane0 && lane1;
  tcfc_cmp_bank #(
    .DEPTH(NUM_CH),
    .WIDTH(CNT_W)
  ) u_bank (
    .clk(clk),
    .rst(rst),
    .wr_en(bank_wr),
    .wr_idx(cmp_off[2:0]),
    .wr_data(req.data[15:0]),
    .rd_idx(cmp_off[2:0]),
    .rd_data(bank_rd),
    .all_words(cmp_words)
  );

  // read mux; the counter word gives a coherent 16-bit snapshot
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = tcfc_pkg::RD_ZERO;
    case (req.idx)
      tcfc_pkg::IDX_FUNC_SEL: rd_mux = {24'h00_0000, func_sel_q};
      tcfc_pkg::IDX_FORCE: rd_mux = tcfc_pkg::RD_ZERO;
      tcfc_pkg::IDX_C7_MASK: rd_mux = {24'h00_0000, c7_mask_q};
      tcfc_pkg::IDX_C7_DATA: rd_mux = {24'h00_0000, c7_data_q};
      tcfc_pkg::IDX_CNT_HI: rd_mux = {24'h00_0000, cnt_q[15:8]};
      tcfc_pkg::IDX_CNT_LO: rd_mux = {24'h00_0000, cnt_q[7:0]};
      tcfc_pkg::IDX_TOGGLE_OVF: rd_mux = {24'h00_0000, tov_q};
      tcfc_pkg::IDX_CNT_WORD: rd_mux = {16'h0000, cnt_q};
      tcfc_pkg::IDX_ACTION: rd_mux = {16'h0000, action_q};
      tcfc_pkg::IDX_CTRL: rd_mux = {30'h0000_0000, ctrl_q};
      tcfc_pkg::IDX_IRQ_STAT: rd_mux = {24'h00_0000, irq_stat_q};
      tcfc_pkg::IDX_IRQ_MASK: rd_mux = {24'h00_0000, irq_mask_q};
      tcfc_pkg::IDX_PIN_STATE: rd_mux = {16'h0000, oe_q, pins_q};
      default: rd_mux = tcfc_pkg::RD_ZERO;
    endcase
  end

  // apb answer: one extra wait state for compare reads since the bank is registered
  wire rd_cmp = req.rd && !bad && is_cmp;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= tcfc_pkg::RD_ZERO;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rd_pend_q <= 1'b0;
      if (rd_pend_q)
      begin
        pready_q <= 1'b1;
        prdata_q <= {16'h0000, bank_rd};
      end
      else if (rd_cmp && !rd_pend_q)
        rd_pend_q <= 1'b1;
      else if (acc)
      begin
        pready_q <= 1'b1;
        pslverr_q <= bad;
        prdata_q <= (req.rd && !bad) ? rd_mux : tcfc_pkg::RD_ZERO;
      end
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin_out = pins_q;
  assign pin_oe = oe_q;
  // interrupt level registered from the next status irq_stat_d and the mask
  logic irq_q;
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_stat_d & irq_mask_q);
  end
  assign irq = irq_q;

  wire unused_ok = &{1'b0, cnt_prev_q, pstrb[3:2]};
endmodule // tcfc_top
`default_nettype wire

// ===== shared/tcfc_pkg.sv
// package for the timer channel config, force and counter block
// assumes apb slave with 32-bit data, byte address = 4 * printed index
package tcfc_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CNT_W = 16;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_FUNC_SEL = 8'h00;
  localparam logic [7:0] IDX_FORCE = 8'h01;
  localparam logic [7:0] IDX_C7_MASK = 8'h02;
  localparam logic [7:0] IDX_C7_DATA = 8'h03;
  localparam logic [7:0] IDX_CNT_HI = 8'h04;
  localparam logic [7:0] IDX_CNT_LO = 8'h05;
  localparam logic [7:0] IDX_TOGGLE_OVF = 8'h07;
  localparam logic [7:0] IDX_CNT_WORD = 8'h40;
  localparam logic [7:0] IDX_CMP_BASE = 8'h41;
  localparam logic [7:0] IDX_ACTION = 8'h49;
  localparam logic [7:0] IDX_CTRL = 8'h4a;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h4b;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h4c;
  localparam logic [7:0] IDX_PIN_STATE = 8'h4d;
  // control bits
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_TEST_BIT = 1;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_ACTION = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // output action per channel: 00 none, 01 toggle, 10 clear, 11 set
  typedef enum logic [1:0] {
    TCFC_ACT_NONE = 2'b00,
    TCFC_ACT_TOGGLE = 2'b01,
    TCFC_ACT_CLEAR = 2'b10,
    TCFC_ACT_SET = 2'b11
  } tcfc_act_t;
  // decoded apb request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [31:0] data;
  } tcfc_req_t;
endpackage

// ===== rtl/tcfc_cmp_bank.sv
// compare value store: eight 16-bit words, registered read port
// assumes one writer and one reader on the same clock
`timescale 1ns/1ns
`default_nettype none
module tcfc_cmp_bank #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // read port, data one cycle after the index
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data,
  // all words for the comparators
  output logic [DEPTH*WIDTH-1:0] all_words
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  // storage, cleared at reset so compares start from a known value
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (wr_en)
      mem_q[wr_idx] <= wr_data;
  end
  // registered read
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data <= '0;
    else
      rd_data <= mem_q[rd_idx];
  end
  // flat view for the comparators
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
      all_words[i*WIDTH +: WIDTH] = mem_q[i];
  end
endmodule // tcfc_cmp_bank

// ===== dv/tcfc_properties.sv
// port checker for tcfc_top
// assumes bind onto tcfc_top, one clock, rst synchronous
`timescale 1ns/1ns
`default_nettype none
module tcfc_properties #(
  parameter int unsigned NUM_CH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // tick, pins, interrupt
  input wire logic tick_in,
  input wire logic [NUM_CH-1:0] pin_out,
  input wire logic [NUM_CH-1:0] pin_oe,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // answered access, and anything that may move pins or flags
  wire acc = psel && penable && pready;
  wire ev = (psel && pwrite) || tick_in;
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_rdy_bound; psel && penable && !pready |-> ##[1:2] pready; endproperty
  a_rdy_bound: assert property (p_rdy_bound) else $error("pready late");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_force_zero; acc && !pwrite && paddr == 12'h004 |-> prdata == 32'h0000_0000; endproperty
  a_force_zero: assert property (p_force_zero) else $error("force reads nonzero");
  property p_unmapped; acc && paddr == 12'h018 |-> pslverr && prdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  // enables follow register writes only; ticks never move them
  property p_oe_cause; !$stable(pin_oe) |-> $past(psel && pwrite) || $past(psel && pwrite, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved uncaused");
  property p_pin_cause; !$stable(pin_out) |-> $past(ev) || $past(ev, 2) || $past(ev, 3); endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin moved uncaused");
  property p_irq_rise; $rose(irq) |-> $past(ev) || $past(ev, 2) || $past(ev, 3); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose uncaused");
  property p_irq_fall; $fell(irq) |-> $past(psel && pwrite) || $past(psel && pwrite, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  c_err: cover property (acc && pslverr);
  c_irq: cover property ($rose(irq));
  c_pin: cover property (!$stable(pin_out));
endmodule // tcfc_properties
bind tcfc_top tcfc_properties #(.NUM_CH(NUM_CH)) u_tcfc_properties (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tick_in(tick_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
`default_nettype wire

// ===== dv/tcfc_pin_model.sv
// board-side model of the timer port pins
// assumes a weak pull-up on every pin
`timescale 1ns/1ns
`default_nettype none
module tcfc_pin_model #(
  parameter int unsigned NUM_CH = 8
) (
  // from the block
  input wire logic [NUM_CH-1:0] pin_out,
  input wire logic [NUM_CH-1:0] pin_oe,
  // resolved levels
  output logic [NUM_CH-1:0] pin_level
);
  // undriven pins float high, so a lost enable never reads as a driven 0
  assign pin_level = (pin_out & pin_oe) | ~pin_oe;
endmodule // tcfc_pin_model
`default_nettype wire

// ===== dv/tcfc_top_test.sv
// self-checking bench for tcfc_top over apb
// assumes 50 MHz clock and the pin model on the port side
`timescale 1ns/1ns
`default_nettype none
module tcfc_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic tick_in = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] pin_level;
  logic irq;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int samples_checked = 0;
  // 20 ns clock
  always #10 clk = ~clk;
  tcfc_top u_tcfc_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tick_in(tick_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq(irq));
  tcfc_pin_model u_tcfc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));
  // verdict and end of run
  task automatic wrap_up();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one comparison; case inequality so x never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s exp=%h got=%h", what, exp, got);
    end
  endtask
  // apb transfer, held until pready is sampled high; bounded wait
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // judge by the answer itself, so a late but valid pready is not a timeout
    if (pready !== 1'b1)
    begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h0000_0000);
    chk(what, exp, rd);
  endtask
  // one prescaler strobe
  task automatic tick();
    @(posedge clk);
    tick_in <= 1'b1;
    @(posedge clk);
    tick_in <= 1'b0;
  endtask
  task automatic t_reset();
    rchk(8'h02, 32'h0000_0000, "mask");
    rchk(8'h40, 32'h0000_0000, "count");
    chk("oe", 32'h0000_0000, {24'h00_0000, pin_oe});
  endtask
  // ch0 compare set-action, ch1 not selected in func_sel_q: force both, only ch0 acts
  task automatic t_force();
    apb(1'b1, 8'h49, 32'h0000_0003);
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b1, 8'h01, 32'h0000_0003);
    repeat (4) @(posedge clk);
    chk("pins", 32'h0000_0001, {24'h00_0000, pin_out});
    chk("oe", 32'h0000_0001, {24'h00_0000, pin_oe});
    rchk(8'h01, 32'h0000_0000, "force");
    rchk(8'h4b, 32'h0000_0000, "flags");
  endtask
  // ch7 forced together with ch0: masked pins take the data bits
  task automatic t_ch7();
    apb(1'b1, 8'h00, 32'h0000_0083);
    apb(1'b1, 8'h02, 32'h0000_0003);
    apb(1'b1, 8'h03, 32'h0000_0002);
    repeat (3) @(posedge clk);
    chk("oe", 32'h0000_0003, {24'h00_0000, pin_oe});
    rchk(8'h03, 32'h0000_0002, "data");
    apb(1'b1, 8'h01, 32'h0000_0081);
    repeat (4) @(posedge clk);
    chk("pins", 32'h0000_0002, {24'h00_0000, pin_out});
    chk("level", 32'h0000_00fe, {24'h00_0000, pin_level});
    rchk(8'h4b, 32'h0000_0000, "flags");
  endtask
  task automatic t_count();
    apb(1'b1, 8'h4a, 32'h0000_0001);
    repeat (3) tick();
    rchk(8'h40, 32'h0000_0003, "count");
    apb(1'b1, 8'h05, 32'h0000_0055);
    rchk(8'h40, 32'h0000_0003, "count");
    apb(1'b1, 8'h4a, 32'h0000_0003);
    apb(1'b1, 8'h04, 32'h0000_00ff);
    apb(1'b1, 8'h05, 32'h0000_00ff);
    rchk(8'h40, 32'h0000_ffff, "count");
    apb(1'b1, 8'h4a, 32'h0000_0001);
    tick();
    rchk(8'h40, 32'h0000_0000, "count");
    // the wrap steps onto the reset compare value 0 of ch0, ch1 and ch7
    rchk(8'h4b, 32'h0000_0083, "flags");
    // ch7 wins over the ch0 set action on the masked pins
    chk("pins", 32'h0000_0002, {24'h00_0000, pin_out});
    // clear the wrap flags so later scenarios start clean
    apb(1'b1, 8'h4b, 32'h0000_00ff);
    rchk(8'h4b, 32'h0000_0000, "flags");
  endtask
  // ch2 match sets its flag; irq follows the mask; write one clears
  task automatic t_irq();
    apb(1'b1, 8'h43, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0087);
    tick();
    rchk(8'h4b, 32'h0000_0004, "flags");
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    apb(1'b1, 8'h4c, 32'h0000_0004);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    apb(1'b1, 8'h4b, 32'h0000_0004);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    rchk(8'h4b, 32'h0000_0000, "flags");
  endtask
  // ch2 toggle: force and a real match on the same edge act once, no flag
  task automatic t_race();
    apb(1'b1, 8'h49, 32'h0000_0013);
    // counter stands at 1 here, so the next tick steps onto 2
    apb(1'b1, 8'h43, 32'h0000_0002);
    fork
      apb(1'b1, 8'h01, 32'h0000_0004);
      begin
        // tick sampled at the same edge as the force write access
        repeat (2) @(posedge clk);
        tick_in <= 1'b1;
        @(posedge clk);
        tick_in <= 1'b0;
      end
    join
    repeat (3) @(posedge clk);
    chk("pins", 32'h0000_0006, {24'h00_0000, pin_out});
    chk("oe", 32'h0000_0007, {24'h00_0000, pin_oe});
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    rchk(8'h4b, 32'h0000_0000, "flags");
    rchk(8'h40, 32'h0000_0002, "count");
  endtask
  task automatic t_unmapped();
    apb(1'b0, 8'h06, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
    chk("rdata", 32'h0000_0000, rd);
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_force();
    t_ch7();
    t_count();
    t_irq();
    t_race();
    t_unmapped();
    wrap_up();
  end
endmodule // tcfc_top_test
`default_nettype wire
